// ===== hdl/pef_pkg.sv
// shared constants, types and mode decoding for the port function select block
package pef_pkg;

	// ==========================================================
	// register map
	localparam int          PEF_ADDR_W       = 8;
	localparam logic [7:0]  PEF_SEL_IDX      = 8'h0a;
	localparam logic [7:0]  PEF_SEL_ADDR     = 8'h28;
	localparam logic [7:0]  PEF_IMPL_MASK    = 8'hbc;

	// ==========================================================
	// field positions
	localparam int PEF_FREE_CYCLE_BIT = 7;
	localparam int PEF_QUEUE_BIT      = 5;
	localparam int PEF_CLK_DIS_BIT    = 4;
	localparam int PEF_STROBE_BIT     = 3;
	localparam int PEF_RW_BIT         = 2;

	// ==========================================================
	// reset values per operating mode
	localparam logic [7:0] PEF_RST_SPECIAL_SINGLE = 8'h00;
	localparam logic [7:0] PEF_RST_SPECIAL_TEST   = 8'h2c;
	localparam logic [7:0] PEF_RST_PERIPHERAL     = 8'h00;
	localparam logic [7:0] PEF_RST_EMULATION      = 8'hac;
	localparam logic [7:0] PEF_RST_NORMAL_SINGLE  = 8'h10;
	localparam logic [7:0] PEF_RST_NORMAL_EXP     = 8'h00;

	// ==========================================================
	// operating modes, encoded as the three mode strap bits
	localparam logic [2:0] PEF_MODE_SPECIAL_SINGLE = 3'h0;
	localparam logic [2:0] PEF_MODE_EMU_NARROW     = 3'h1;
	localparam logic [2:0] PEF_MODE_SPECIAL_TEST   = 3'h2;
	localparam logic [2:0] PEF_MODE_EMU_WIDE       = 3'h3;
	localparam logic [2:0] PEF_MODE_NORMAL_SINGLE  = 3'h4;
	localparam logic [2:0] PEF_MODE_NORMAL_NARROW  = 3'h5;
	localparam logic [2:0] PEF_MODE_PERIPHERAL     = 3'h6;
	localparam logic [2:0] PEF_MODE_NORMAL_WIDE    = 3'h7;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [PEF_ADDR_W-1:0] address;
		logic                  read;
		logic                  write;
		logic [3:0]            byteenable;
		logic [31:0]           writedata;
	} pef_avl_req_t;

	typedef struct packed {
		logic free_cycle;
		logic queue_status_hi;
		logic queue_status_lo;
		logic low_byte_strobe;
		logic read_write;
	} pef_ctl_src_t;

	// ==========================================================
	// mode classes
	function automatic logic pef_is_single(input logic [2:0] m);
		return (m == PEF_MODE_SPECIAL_SINGLE) || (m == PEF_MODE_NORMAL_SINGLE);
	endfunction

	function automatic logic pef_is_emulation(input logic [2:0] m);
		return (m == PEF_MODE_EMU_NARROW) || (m == PEF_MODE_EMU_WIDE);
	endfunction

	function automatic logic pef_is_normal(input logic [2:0] m);
		return m[2] && (m != PEF_MODE_PERIPHERAL);
	endfunction

endpackage

// ===== hdl/pef_write_gate.sv
// per-bit write permission of the function select register
`timescale 1ns/100ps
module pef_write_gate
	import pef_pkg::*;
(
	// operating mode
	input  wire logic [2:0] mode_sel,
	// bits already written once since reset
	input  wire logic [7:0] written,
	// bits that the current write may change
	output logic      [7:0] wr_mask
);

	// ==========================================================
	// mode classes
	wire logic normal_mode;
	wire logic emu_mode;
	wire logic special_mode;
	wire logic [7:0] once_bits;

	assign normal_mode  = pef_is_normal(mode_sel);
	assign emu_mode     = pef_is_emulation(mode_sel);
	assign special_mode = !normal_mode && !emu_mode;
	assign once_bits    = PEF_IMPL_MASK & ~(8'h01 << PEF_CLK_DIS_BIT);

	// ==========================================================
	// permission per bit
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_bit
			if (!PEF_IMPL_MASK[b]) begin : g_none
				assign wr_mask[b] = 1'b0;
			end else if (b == PEF_CLK_DIS_BIT) begin : g_clk
				assign wr_mask[b] = !emu_mode;
			end else begin : g_once
				assign wr_mask[b] = special_mode || (normal_mode && once_bits[b] && !written[b]);
			end
		end
	endgenerate

endmodule

// ===== hdl/pef_pin_cell.sv
// one port pin: alternate function or general purpose output
`timescale 1ns/100ps
module pef_pin_cell (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// alternate function
	input  wire logic alt_sel,
	input  wire logic alt_out,
	input  wire logic alt_oe,
	// general purpose
	input  wire logic gp_out,
	input  wire logic gp_dir,
	// pin
	output logic      pin_out,
	output logic      pin_oe
);

	// ==========================================================
	// selection
	wire logic out_next;
	wire logic oe_next;

	// alternate function overrides the direction bit
	assign out_next = alt_sel ? alt_out : gp_out;
	assign oe_next  = alt_sel ? alt_oe : gp_dir;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else begin
			pin_out <= out_next;
			pin_oe  <= oe_next;
		end
	end

endmodule

// ===== hdl/pef_pin_mux.sv
// port function select register and pin multiplexer for port pins 7:2
//
// Contract
// - alternate function overrides pin direction bit
// - normal single chip resets to clock-disable only
// - normal expanded resets all zero, clock enabled
// - test and emulation reset enable bus controls
// - readable while mapped; per-bit write permission
// - expanded and peripheral accesses go external
// - free-cycle bit once, never, anytime by mode
// - free-cycle zero drives pin 7 indicator in expanded modes
// - queue status bit drives pins 6:5
// - queue status inert in single chip, peripheral
// - clock disable anytime except emulation, selects pin4
// - bus clock free running when stretch zero
// - strobe enable drives pin 3 strobe
// - tagging samples tag on rise, strobe falls
// - strobe inert single chip, peripheral, normal narrow
// - read/write enable drives pin 2 in expanded modes
`timescale 1ns/100ps
module pef_pin_mux
	import pef_pkg::*;
#(
	parameter int ADDR_W = PEF_ADDR_W
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// operating mode straps, held stable
	input  wire logic [2:0]        mode_sel,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [3:0]        avs_byteenable,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// access handed to the external bus
	output logic                   ext_forward,
	// general purpose port state
	input  wire logic [7:0]        port_data_reg,
	input  wire logic [7:0]        port_direction_reg,
	// bus control sources
	input  wire pef_ctl_src_t      ctl_src,
	input  wire logic              bus_clock_src,
	input  wire logic              bus_cycle_active,
	input  wire logic              bus_clock_stretch_ctl,
	input  wire logic              background_debug_tag_en,
	// pins 7:2
	input  wire logic [7:2]        pin_in,
	output logic      [7:2]        pin_out,
	output logic      [7:2]        pin_oe,
	// captured tag and function select readback
	output logic                   low_tag_input,
	output logic      [7:0]        pin_function_select
);

	// ==========================================================
	// state
	logic [7:0] pin_function_select_reg;
	logic [7:0] pin_function_select_next;
	logic [7:0] written_reg;
	logic [7:0] written_next;
	logic       init_pending_reg;
	logic       ack_reg;
	logic       ack_next;
	logic [31:0] readdata_reg;
	logic [31:0] readdata_next;
	logic       ext_forward_reg;
	logic       ext_forward_next;
	logic       clk_prev_reg;
	logic       low_tag_reg;
	logic       strobe_out_reg;

	// ==========================================================
	// mode decoding
	wire logic single_mode;
	wire logic peripheral_mode;
	wire logic expanded_mode;
	wire logic narrow_normal;
	wire logic reg_in_map;

	assign single_mode     = pef_is_single(mode_sel);
	assign peripheral_mode = (mode_sel == PEF_MODE_PERIPHERAL);
	assign expanded_mode   = !single_mode && !peripheral_mode;
	assign narrow_normal   = (mode_sel == PEF_MODE_NORMAL_NARROW);
	// present on chip only in single chip modes
	assign reg_in_map      = single_mode;

	// ==========================================================
	// reset value chosen by mode
	wire logic [7:0] mode_reset_value;

	function automatic logic [7:0] pef_reset_value(input logic [2:0] m);
		logic [7:0] v;
		v = PEF_RST_NORMAL_EXP;
		case (m)
			PEF_MODE_SPECIAL_SINGLE: v = PEF_RST_SPECIAL_SINGLE;
			PEF_MODE_SPECIAL_TEST:   v = PEF_RST_SPECIAL_TEST;
			PEF_MODE_PERIPHERAL:     v = PEF_RST_PERIPHERAL;
			PEF_MODE_EMU_NARROW:     v = PEF_RST_EMULATION;
			PEF_MODE_EMU_WIDE:       v = PEF_RST_EMULATION;
			PEF_MODE_NORMAL_SINGLE:  v = PEF_RST_NORMAL_SINGLE;
			PEF_MODE_NORMAL_NARROW:  v = PEF_RST_NORMAL_EXP;
			PEF_MODE_NORMAL_WIDE:    v = PEF_RST_NORMAL_EXP;
			default:                 v = PEF_RST_NORMAL_EXP;
		endcase
		return v;
	endfunction

	// normal single chip value has only the clock disable set
	// expanded normal value keeps the bus clock on for the vector fetch
	// test and emulation values enable the bus controls
	assign mode_reset_value = pef_reset_value(mode_sel);

	// ==========================================================
	// bus decode
	wire logic req_any;
	wire logic hit_sel;
	wire logic take;
	wire logic wr_take;
	wire logic [7:0] wr_mask;
	wire logic [7:0] wr_data;

	assign req_any = avs_read || avs_write;
	assign hit_sel = (avs_address == PEF_SEL_ADDR[ADDR_W-1:0]);
	// one wait state; no request is taken until the mode value is loaded
	assign take    = req_any && !ack_reg && !init_pending_reg;
	assign wr_take = ack_reg && avs_write && hit_sel && reg_in_map && avs_byteenable[0];
	assign wr_data = avs_writedata[7:0];

	pef_write_gate u_write_gate (
		.mode_sel (mode_sel),
		.written  (written_reg),
		.wr_mask  (wr_mask)
	);

	// ==========================================================
	// register update
	always_comb begin
		pin_function_select_next = pin_function_select_reg;
		written_next             = written_reg;
		if (init_pending_reg) begin
			pin_function_select_next = mode_reset_value & PEF_IMPL_MASK;
		end else if (wr_take) begin
			// each bit changes only where permitted
			pin_function_select_next = ((pin_function_select_reg & ~wr_mask) | (wr_data & wr_mask)) & PEF_IMPL_MASK;
			// later writes to write-once bits are dropped
			written_next = written_reg | PEF_IMPL_MASK;
		end
	end

	// ==========================================================
	// answer
	always_comb begin
		ack_next         = take;
		readdata_next    = readdata_reg;
		ext_forward_next = 1'b0;
		if (take) begin
			readdata_next = 32'h0000_0000;
			if (hit_sel && reg_in_map) begin
				// readable whenever mapped; unused bits read zero
				readdata_next = {24'h00_0000, pin_function_select_reg & PEF_IMPL_MASK};
			end
			// absent register hands the access to the external bus
			ext_forward_next = hit_sel && !reg_in_map;
		end
	end

	assign avs_waitrequest = !ack_reg;
	assign avs_readdata    = readdata_reg;
	assign ext_forward     = ext_forward_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_function_select_reg <= 8'h00;
			written_reg             <= 8'h00;
			init_pending_reg        <= 1'b1;
		end else begin
			pin_function_select_reg <= pin_function_select_next;
			written_reg             <= written_next;
			init_pending_reg        <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack_reg         <= 1'b0;
			readdata_reg    <= 32'h0000_0000;
			ext_forward_reg <= 1'b0;
		end else begin
			ack_reg         <= ack_next;
			readdata_reg    <= readdata_next;
			ext_forward_reg <= ext_forward_next;
		end
	end

	assign pin_function_select = pin_function_select_reg;

	// ==========================================================
	// effective selections
	wire logic free_cycle_out_sel;
	wire logic queue_status_out_en;
	wire logic bus_clock_pin_disable;
	wire logic low_byte_strobe_en;
	wire logic read_write_pin_en;
	wire logic sel_free;
	wire logic sel_queue;
	wire logic sel_clock;
	wire logic sel_strobe;
	wire logic sel_rw;

	assign free_cycle_out_sel    = pin_function_select_reg[PEF_FREE_CYCLE_BIT];
	assign queue_status_out_en   = pin_function_select_reg[PEF_QUEUE_BIT];
	assign bus_clock_pin_disable = pin_function_select_reg[PEF_CLK_DIS_BIT];
	assign low_byte_strobe_en    = pin_function_select_reg[PEF_STROBE_BIT];
	assign read_write_pin_en     = pin_function_select_reg[PEF_RW_BIT];

	// zero selects the free cycle indicator, inert outside expanded modes
	assign sel_free   = !free_cycle_out_sel && expanded_mode;
	// inert in single chip and peripheral modes
	assign sel_queue  = queue_status_out_en && expanded_mode;
	// zero puts the bus clock on pin 4 in every mode
	assign sel_clock  = !bus_clock_pin_disable;
	// not in narrow normal mode either
	assign sel_strobe = low_byte_strobe_en && expanded_mode && !narrow_normal;
	assign sel_rw     = read_write_pin_en && expanded_mode;

	// ==========================================================
	// bus clock and tag multiplexing
	wire logic bus_clock_out;
	wire logic clk_rise;
	wire logic clk_fall;
	wire logic tagging;

	// free running with stretch off, else only during bus cycles
	assign bus_clock_out = bus_clock_src && (!bus_clock_stretch_ctl || bus_cycle_active);
	assign clk_rise      = bus_clock_src && !clk_prev_reg;
	assign clk_fall      = !bus_clock_src && clk_prev_reg;
	assign tagging       = sel_strobe && background_debug_tag_en;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clk_prev_reg   <= 1'b0;
			low_tag_reg    <= 1'b0;
			strobe_out_reg <= 1'b0;
		end else begin
			clk_prev_reg <= bus_clock_src;
			// tag taken at rise, strobe launched at fall
			if (tagging && clk_rise) begin
				low_tag_reg <= pin_in[PEF_STROBE_BIT];
			end
			if (clk_fall) begin
				strobe_out_reg <= ctl_src.low_byte_strobe;
			end
		end
	end

	assign low_tag_input = low_tag_reg;

	// ==========================================================
	// per-pin alternate functions
	wire logic [7:2] alt_sel;
	wire logic [7:2] alt_out;
	wire logic [7:2] alt_oe;
	wire logic       strobe_level;
	wire logic       strobe_oe;

	// pin 3 is released while the clock is high so the tag can be read
	assign strobe_level = tagging ? strobe_out_reg : ctl_src.low_byte_strobe;
	assign strobe_oe    = tagging ? !bus_clock_src : 1'b1;

	assign alt_sel = {sel_free, sel_queue, sel_queue, sel_clock, sel_strobe, sel_rw};
	assign alt_out = {ctl_src.free_cycle, ctl_src.queue_status_hi, ctl_src.queue_status_lo,
	                  bus_clock_out, strobe_level, ctl_src.read_write};
	assign alt_oe  = {1'b1, 1'b1, 1'b1, 1'b1, strobe_oe, 1'b1};

	genvar p;
	generate
		for (p = 2; p < 8; p++) begin : g_pin
			pef_pin_cell u_cell (
				.ref_clk (ref_clk),
				.rst     (rst),
				.alt_sel (alt_sel[p]),
				.alt_out (alt_out[p]),
				.alt_oe  (alt_oe[p]),
				.gp_out  (port_data_reg[p]),
				.gp_dir  (port_direction_reg[p]),
				.pin_out (pin_out[p]),
				.pin_oe  (pin_oe[p])
			);
		end
	endgenerate

endmodule

// ===== test/pef_checker.sv
// assertion checker for the port function select block
`timescale 1ns/100ps
module pef_checker
	import pef_pkg::*;
(
	// clock and reset
	input wire logic         ref_clk,
	input wire logic         rst,
	// bus side
	input wire logic [2:0]   mode_sel,
	input wire logic         avs_read,
	input wire logic         avs_write,
	input wire logic [31:0]  avs_readdata,
	input wire logic         avs_waitrequest,
	input wire logic         ext_forward,
	// pin side
	input wire logic [7:0]   port_data_reg,
	input wire logic [7:0]   port_direction_reg,
	input wire pef_ctl_src_t ctl_src,
	input wire logic [7:2]   pin_out,
	input wire logic [7:2]   pin_oe,
	input wire logic [7:0]   pin_function_select
);
	// ==========================================
	// mode classes
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire mapped = mode_sel == 3'h0 || mode_sel == 3'h4;
	wire xp     = !mapped && mode_sel != 3'h6;
	wire emu    = !mode_sel[2] && mode_sel[0];
	// ==========================================
	// properties
	chk_ack_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	chk_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
		else $error("answer without a request");
	chk_fwd_absent: assert property (ext_forward |-> !mapped && !avs_waitrequest)
		else $error("forward while register mapped");
	chk_absent_zero: assert property (!avs_waitrequest && avs_read && !mapped |-> avs_readdata == 32'h0)
		else $error("absent register read not zero");
	chk_unused_zero: assert property (pin_function_select[6] == 1'b0 && pin_function_select[1:0] == 2'h0)
		else $error("unused select bits not zero");
	chk_emu_frozen: assert property (emu && $past(pin_function_select) == 8'hac |-> pin_function_select == 8'hac)
		else $error("select changed in emulation");
	chk_free_cycle: assert property (xp && !pin_function_select[7] |=> pin_oe[7] && pin_out[7] == $past(ctl_src.free_cycle))
		else $error("pin 7 not free cycle output");
	chk_queue_inert: assert property (!xp |=> pin_oe[6:5] == $past(port_direction_reg[6:5]) && pin_out[6:5] == $past(port_data_reg[6:5]))
		else $error("pins 6:5 not general purpose");
	chk_strobe_narrow: assert property (mode_sel == 3'h5 |=> pin_oe[3] == $past(port_direction_reg[3]))
		else $error("strobe active in narrow mode");
	chk_rw_pin: assert property (xp && pin_function_select[2] |=> pin_oe[2] && pin_out[2] == $past(ctl_src.read_write))
		else $error("pin 2 not read write output");
endmodule

bind pef_pin_mux pef_checker chk (.*);

// ===== test/pef_ext_model.sv
// far side of the port pins: external bus party
`timescale 1ns/100ps
module pef_ext_model (
	// pins from the block
	input wire logic [7:2] pin_out,
	input wire logic [7:2] pin_oe,
	// level put on pins the block has released
	input wire logic [7:2] ext_lvl,
	// resolved pin levels
	output logic     [7:2] pin_in
);
	// tag driven only while pin released
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

// ===== test/testbench.sv
// self-checking bench for the port function select block
`timescale 1ns/100ps
module testbench
	import pef_pkg::*;
;
	// ==========================================
	// signals
	logic         ref_clk = 1'b0;
	logic         rst = 1'b1;
	logic [2:0]   mode_sel = 3'h0;
	logic [7:0]   avs_address = 8'h00;
	logic         avs_read = 1'b0;
	logic         avs_write = 1'b0;
	logic [3:0]   avs_byteenable = 4'h0;
	logic [31:0]  avs_writedata = 32'h0;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	logic         ext_forward;
	logic [7:0]   port_data_reg = 8'h00;
	logic [7:0]   port_direction_reg = 8'h00;
	pef_ctl_src_t ctl_src = '0;
	logic         bus_clock_src = 1'b0;
	logic         bus_cycle_active = 1'b0;
	logic         bus_clock_stretch_ctl = 1'b0;
	logic         background_debug_tag_en = 1'b0;
	logic [7:2]   ext_lvl = 6'h00;
	logic [7:2]   pin_in;
	logic [7:2]   pin_out;
	logic [7:2]   pin_oe;
	logic         low_tag_input;
	logic [7:0]   pin_function_select;
	int           num_errors = 0;
	int           n_checks = 0;
	logic [31:0]  seed = 32'd95241;
	logic [7:0]   mreg;
	bit           once;
	logic [31:0]  q;
	logic         f;
	logic [7:0]   rv [8] = '{8'h00, 8'hac, 8'h2c, 8'hac, 8'h10, 8'h00, 8'h00, 8'h00};

	always #4 ref_clk = ~ref_clk;

	pef_pin_mux uut (.*);
	pef_ext_model ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

	// ==========================================
	// helpers and model
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic bit mp();
		return mode_sel == 3'h0 || mode_sel == 3'h4;
	endfunction

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// only the first accepted write in normal mode may set the once bits
	task automatic mwrite(input logic [7:0] d, input bit b0);
		logic [7:0] pm;
		pm = 8'h00;
		if (b0 && mp()) begin
			pm = (mode_sel == 3'h4 && once) ? 8'h10 : 8'hbc;
			once = 1'b1;
		end
		mreg = (mreg & ~pm) | (d & pm);
	endtask

	task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d, input bit b0);
		int k;
		@(posedge ref_clk);
		avs_address    <= a;
		avs_read       <= !w;
		avs_write      <= w;
		avs_byteenable <= {3'h7, b0};
		avs_writedata  <= {24'h0, d};
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		q = avs_readdata;
		f = ext_forward;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
			summarize();
		end
	endtask

	task automatic rst_to(input logic [2:0] m);
		@(posedge ref_clk);
		rst      <= 1'b1;
		mode_sel <= m;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		mreg = rv[m];
		once = 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic pins();
		logic [7:2] sel;
		logic [7:2] alt;
		bit         xp;
		@(posedge ref_clk);
		seed = lfsr(seed);
		port_data_reg         <= seed[7:0];
		port_direction_reg    <= seed[15:8];
		ctl_src               <= seed[20:16];
		bus_clock_src         <= seed[21];
		bus_cycle_active      <= seed[22];
		bus_clock_stretch_ctl <= seed[23];
		ext_lvl               <= seed[29:24];
		repeat (2) @(posedge ref_clk);
		#1;
		xp  = !(mp() || mode_sel == 3'h6);
		sel = {!mreg[7] && xp, mreg[5] && xp, mreg[5] && xp, !mreg[4], mreg[3] && xp && mode_sel != 3'h5, mreg[2] && xp};
		alt = {ctl_src.free_cycle, ctl_src.queue_status_hi, ctl_src.queue_status_lo,
			bus_clock_src & (!bus_clock_stretch_ctl | bus_cycle_active), ctl_src.low_byte_strobe, ctl_src.read_write};
		chk("pin_out", 32'(pin_out), 32'((sel & alt) | (~sel & port_data_reg[7:2])));
		chk("pin_oe", 32'(pin_oe), 32'(sel | port_direction_reg[7:2]));
	endtask

	// ==========================================
	// scenarios
	initial begin
		for (int m = 0; m < 8; m++) begin
			rst_to(m[2:0]);
			chk("reset value", 32'(pin_function_select), 32'(rv[m]));
			bus(1'b0, 8'h28, 8'h00, 1'b1);
			chk("read", q, 32'(mp() ? mreg : 8'h00));
			chk("forward", 32'(f), 32'(!mp()));
			// first write has byte lane 0 disabled, so it must change nothing
			bus(1'b1, 8'h28, 8'hff, 1'b0);
			mwrite(8'hff, 1'b0);
			seed = lfsr(seed);
			bus(1'b1, 8'h28, seed[7:0], 1'b1);
			mwrite(seed[7:0], 1'b1);
			bus(1'b1, 8'h28, ~seed[7:0], 1'b1);
			mwrite(~seed[7:0], 1'b1);
			bus(1'b0, 8'h28, 8'h00, 1'b1);
			chk("readback", q, 32'(mp() ? mreg : 8'h00));
			chk("select", 32'(pin_function_select), 32'(mreg));
			bus(1'b0, 8'h2c, 8'h00, 1'b1);
			chk("unmapped read", q, 32'h0);
			repeat (6) pins();
		end
		// tag capture: strobe and far side agree so the one-cycle oe lag cannot matter
		rst_to(3'h2);
		background_debug_tag_en <= 1'b1;
		for (int v = 0; v < 2; v++) begin
			@(posedge ref_clk);
			bus_clock_src           <= 1'b1;
			ctl_src.low_byte_strobe <= v[0];
			ext_lvl[3]              <= v[0];
			repeat (3) @(posedge ref_clk);
			bus_clock_src <= 1'b0;
			repeat (3) @(posedge ref_clk);
			bus_clock_src <= 1'b1;
			repeat (3) @(posedge ref_clk);
			#1;
			chk("tag", 32'(low_tag_input), 32'(v[0]));
			chk("tag pin oe", 32'(pin_oe[3]), 32'h0);
		end
		summarize();
	end
endmodule
